// [verilog/ssp_port.sv]
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
// Overview of operation
// - Enable hands clock and data pins to port
// - Enable clear disables port, releases pins
// - Eight bits shift out and in together
// - Shift register moves MSb first
// - Full byte goes to buffer, sets flags
// - Receive path double buffered
// - Buffer write during transfer ignored, collision set
// - Collision flag held until software clears it
// - Buffer read clears buffer full
// - Software reads buffer before next write
// - Master drives clock, slave takes it
// - Rate for master, select for slave only
// - Software configures mode before use
// - Slave has optional active-low select input
// - Polling software avoids write collisions
// - Mode codes pick master or slave, select
// - Master rate: clock/4, /16, /64, timer/2
// - Select high stops transfer, floats data out
// - Slave byte onto full buffer sets overflow
module ssp_port
    import ssp_pkg::*;
(
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Rate source
    input  wire logic        timer_two_output_i,
    // Serial link
    ssp_link_if.dev          link
);
    ssp_state_t          state;
    logic                write_collision_flag;
    logic                ovf;
    logic                en;
    logic                clock_polarity_select;
    logic [3:0]          mode;
    logic                bf;
    logic                port_if;
    logic [SSP_BITS-1:0] sr;
    logic [SSP_BITS-1:0] rx_buf;
    logic [2:0]          cnt;
    logic [5:0]          div_cnt;
    logic                sck_q;
    logic                sck_oe_q;
    logic                sdo_q;
    logic                sdo_oe_q;
    logic                sck_prev;

    logic                is_master;
    logic                is_slave;
    logic                ss_ctrl;
    logic                sel_ok;
    logic                busy;
    logic                acc;
    logic                wr;
    logic                rd;
    logic                buf_wr;
    logic                buf_rd;
    logic                collide;
    logic                load;
    logic [5:0]          half;
    logic                tick;
    logic                m_edge;
    logic                s_edge;
    logic                drive;
    logic                sample;
    logic                done;
    logic [SSP_BITS-1:0] shifted;
    logic [31:0]         rd_word;

    // Mode decode
    assign is_master = (mode[3:2] == 2'b00);
    assign is_slave  = (mode[3:1] == 3'b010);
    assign ss_ctrl   = is_slave && (mode == MODE_S_SS);
    assign sel_ok    = !ss_ctrl || !link.ss_n;

    // Bus strobes; effects land on the edge that sees ack high
    assign acc    = wb_cyc_i && wb_stb_i && wb_ack_o;
    assign wr     = acc && wb_we_i && wb_sel_i[0];
    assign rd     = acc && !wb_we_i;
    assign buf_wr = wr && (wb_adr_i == SSP_OFF_BUF);
    assign buf_rd = rd && (wb_adr_i == SSP_OFF_BUF);

    // A slave counts as busy once its first bit is sampled
    assign busy    = is_master ? (state == SSP_RUN) : (cnt != 3'h0);
    assign collide = buf_wr && en && busy;
    assign load    = buf_wr && en && !busy;

    always_comb
    begin
        unique case (mode[1:0])
            2'b00:   half = HALF_DIV4;
            2'b01:   half = HALF_DIV16;
            2'b10:   half = HALF_DIV64;
            2'b11:   half = HALF_DIV4;
        endcase
    end

    // Timer pulses toggle the clock, so the bit rate is half of it
    assign tick = (mode[1:0] == 2'b11) ? timer_two_output_i
                                       : (div_cnt == half - 6'h01);

    assign m_edge = en && is_master && state == SSP_RUN && tick;
    assign s_edge = en && is_slave && sel_ok && link.sck != sck_prev;
    // Leaving the idle level drives, returning to it samples
    assign drive  = m_edge ? (sck_q == clock_polarity_select)
                           : (s_edge && link.sck != clock_polarity_select);
    assign sample = m_edge ? (sck_q != clock_polarity_select)
                           : (s_edge && link.sck == clock_polarity_select);
    assign done    = sample && cnt == 3'h7;
    assign shifted = {sr[SSP_BITS-2:0], link.dev_sdi};

    assign link.dev_sck_o  = sck_q;
    assign link.dev_sck_oe = sck_oe_q;
    assign link.dev_sdo_o  = sdo_q;
    assign link.dev_sdo_oe = sdo_oe_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || state != SSP_RUN || div_cnt == half - 6'h01)
            div_cnt <= 6'h00;
        else
            div_cnt <= div_cnt + 6'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= SSP_IDLE;
            sck_q <= 1'b0;
        end
        else if (!en)
        begin
            state <= SSP_IDLE;
            sck_q <= clock_polarity_select;
        end
        else
        begin
            unique case (state)
                SSP_IDLE:
                begin
                    sck_q <= clock_polarity_select;
                    if (load && is_master)
                        state <= SSP_RUN;
                end
                SSP_RUN:
                begin
                    if (m_edge)
                        sck_q <= !sck_q;
                    if (done)
                        state <= SSP_IDLE;
                end
            endcase
        end
    end

    // Pin ownership
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sck_oe_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            sck_prev <= 1'b0;
        end
        else
        begin
            sck_prev <= link.sck;
            sck_oe_q <= en && is_master;
            sdo_oe_q <= en && (is_master || (is_slave && sel_ok));
        end
    end

    // Shift engine; bits kept while deselected so a byte resumes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sr    <= '0;
            cnt   <= 3'h0;
            sdo_q <= 1'b0;
        end
        else if (!en)
            cnt <= 3'h0;
        else if (load)
        begin
            sr    <= wb_dat_i[SSP_BITS-1:0];
            sdo_q <= wb_dat_i[SSP_BITS-1];
        end
        else if (sample)
        begin
            sr  <= shifted;
            cnt <= cnt + 3'h1;
        end
        else if (drive)
            sdo_q <= sr[SSP_BITS-1];
    end

    // Receive buffer and its flags; a set beats a same-cycle clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_buf  <= '0;
            bf      <= 1'b0;
            port_if <= 1'b0;
        end
        else
        begin
            if (done && !(is_slave && bf))
            begin
                rx_buf  <= shifted;
                bf      <= 1'b1;
                port_if <= 1'b1;
            end
            else
            begin
                if (buf_rd)
                    bf <= 1'b0;
                if (wr && wb_adr_i == SSP_OFF_STAT
                    && !wb_dat_i[STAT_IF_BIT])
                    port_if <= 1'b0;
            end
        end
    end

    // Control register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {write_collision_flag, ovf, en, clock_polarity_select, mode} <= CTRL_RESET;
        end
        else
        begin
            if (wr && wb_adr_i == SSP_OFF_CTRL)
            begin
                en   <= wb_dat_i[CTRL_EN_BIT];
                clock_polarity_select  <= wb_dat_i[CTRL_CKP_BIT];
                mode <= wb_dat_i[CTRL_MODE_LSB +: 4];
                write_collision_flag <= wb_dat_i[CTRL_WRITE_COLLISION_FLAG_BIT];
                ovf  <= wb_dat_i[CTRL_OVF_BIT];
            end
            if (collide)
                write_collision_flag <= 1'b1;
            if (done && is_slave && bf)
                ovf <= 1'b1;
        end
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (wb_adr_i)
            SSP_OFF_CTRL:
            begin
                rd_word[CTRL_WRITE_COLLISION_FLAG_BIT]         = write_collision_flag;
                rd_word[CTRL_OVF_BIT]          = ovf;
                rd_word[CTRL_EN_BIT]           = en;
                rd_word[CTRL_CKP_BIT]          = clock_polarity_select;
                rd_word[CTRL_MODE_LSB +: 4]    = mode;
            end
            SSP_OFF_STAT:
            begin
                rd_word[STAT_BF_BIT]   = bf;
                rd_word[STAT_IF_BIT]   = port_if;
                rd_word[STAT_BUSY_BIT] = busy;
            end
            SSP_OFF_BUF:
                rd_word[SSP_BITS-1:0] = rx_buf;
            default:
                rd_word = 32'h0000_0000;
        endcase
    end

    // One wait state: ack follows the request by one edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o)
                wb_dat_o <= rd_word;
        end
    end
endmodule : ssp_port

// [verilog/ssp_pkg.sv]
package ssp_pkg;
    localparam int SSP_BITS = 8;

    // Wishbone word offsets (bytes)
    localparam logic [7:0] SSP_OFF_CTRL = 8'h00;
    localparam logic [7:0] SSP_OFF_STAT = 8'h04;
    localparam logic [7:0] SSP_OFF_BUF  = 8'h08;

    // Control register fields
    localparam int CTRL_WRITE_COLLISION_FLAG_BIT = 7;
    localparam int CTRL_OVF_BIT  = 6;
    localparam int CTRL_EN_BIT   = 5;
    localparam int CTRL_CKP_BIT  = 4;
    localparam int CTRL_MODE_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Status register fields
    localparam int STAT_BF_BIT   = 0;
    localparam int STAT_IF_BIT   = 1;
    localparam int STAT_BUSY_BIT = 2;

    // Mode field codes
    localparam logic [3:0] MODE_M_DIV4  = 4'h0;
    localparam logic [3:0] MODE_M_DIV16 = 4'h1;
    localparam logic [3:0] MODE_M_DIV64 = 4'h2;
    localparam logic [3:0] MODE_M_TMR   = 4'h3;
    localparam logic [3:0] MODE_S_SS    = 4'h4;
    localparam logic [3:0] MODE_S_NOSS  = 4'h5;

    // Half bit periods in clk_i cycles for the divided rates
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;

    typedef enum logic {
        SSP_IDLE = 1'b0,
        SSP_RUN  = 1'b1
    } ssp_state_t;

    typedef enum logic [1:0] {
        PEER_IDLE = 2'b00,
        PEER_RUN  = 2'b01,
        PEER_LAST = 2'b11
    } ssp_peer_state_t;
endpackage : ssp_pkg

// [verilog/ssp_link_if.sv]
`timescale 1ns/100ps
interface ssp_link_if;
    logic dev_sck_o;
    logic dev_sck_oe;
    logic dev_sdo_o;
    logic dev_sdo_oe;
    logic peer_sck_o;
    logic peer_sck_oe;
    logic peer_sdo_o;
    logic peer_sdo_oe;
    logic peer_ss_n_o;
    logic sck;
    logic dev_sdi;
    logic peer_sdi;
    logic ss_n;

    // Undriven wires read low, as with a weak pull-down
    assign sck      = dev_sck_oe ? dev_sck_o
                    : (peer_sck_oe ? peer_sck_o : 1'b0);
    assign dev_sdi  = peer_sdo_oe ? peer_sdo_o : 1'b0;
    assign peer_sdi = dev_sdo_oe ? dev_sdo_o : 1'b0;
    assign ss_n     = peer_ss_n_o;

    modport dev (
        output dev_sck_o, dev_sck_oe, dev_sdo_o, dev_sdo_oe,
        input  sck, dev_sdi, ss_n
    );
    modport peer (
        output peer_sck_o, peer_sck_oe, peer_sdo_o, peer_sdo_oe,
        output peer_ss_n_o,
        input  sck, peer_sdi
    );
endinterface : ssp_link_if

// [verilog/ssp_peer.sv]
`timescale 1ns/100ps
module ssp_peer
    import ssp_pkg::*;
#(
    parameter int HALF_CYCLES = 4
)
(
    // System
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // User side
    input  wire logic                master_mode_i,
    input  wire logic                ckp_i,
    input  wire logic                start_i,
    input  wire logic [SSP_BITS-1:0] tx_data_i,
    output logic                     busy_o,
    output logic [SSP_BITS-1:0]      rx_data_o,
    output logic                     rx_valid_o,
    // Link
    ssp_link_if.peer                 link
);
    localparam logic [7:0] HALF_M1 = 8'(HALF_CYCLES - 1);

    ssp_peer_state_t     state;
    logic [7:0]          hcnt;
    logic [2:0]          cnt;
    logic [SSP_BITS-1:0] sr;
    logic                sck_q;
    logic                sck_prev;
    logic                sdo_q;
    logic                ss_n_q;
    logic                drv_q;
    logic                tick;
    logic                busy;
    logic                load;
    logic                lead;
    logic                trail;

    assign tick  = (hcnt == HALF_M1);
    assign busy  = master_mode_i ? (state != PEER_IDLE) : (cnt != 3'h0);
    assign load  = start_i && !busy;
    // Master acts on its own toggles, slave on the far end's clock
    assign lead  = master_mode_i
                 ? (state == PEER_RUN && tick && sck_q == ckp_i)
                 : (link.sck != sck_prev && link.sck != ckp_i);
    assign trail = master_mode_i
                 ? (state == PEER_RUN && tick && sck_q != ckp_i)
                 : (link.sck != sck_prev && link.sck == ckp_i);

    assign link.peer_sck_o  = sck_q;
    assign link.peer_sck_oe = drv_q && master_mode_i;
    assign link.peer_sdo_o  = sdo_q;
    assign link.peer_sdo_oe = drv_q;
    assign link.peer_ss_n_o = ss_n_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || state == PEER_IDLE || tick)
            hcnt <= 8'h00;
        else
            hcnt <= hcnt + 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state  <= PEER_IDLE;
            ss_n_q <= 1'b1;
            sck_q  <= 1'b0;
        end
        else
        begin
            unique case (state)
                PEER_IDLE:
                begin
                    sck_q <= ckp_i;
                    if (load && master_mode_i)
                    begin
                        state  <= PEER_RUN;
                        ss_n_q <= 1'b0;
                    end
                end
                PEER_RUN:
                begin
                    if (tick)
                        sck_q <= !sck_q;
                    if (trail && cnt == 3'h7)
                        state <= PEER_LAST;
                end
                PEER_LAST:
                begin
                    // Select stays low half a bit past the last edge
                    if (tick)
                    begin
                        state  <= PEER_IDLE;
                        ss_n_q <= 1'b1;
                    end
                end
                default:
                    state <= PEER_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sr         <= '0;
            cnt        <= 3'h0;
            sdo_q      <= 1'b0;
            drv_q      <= 1'b0;
            sck_prev   <= 1'b0;
            rx_data_o  <= '0;
            rx_valid_o <= 1'b0;
            busy_o     <= 1'b0;
        end
        else
        begin
            drv_q      <= 1'b1;
            sck_prev   <= link.sck;
            busy_o     <= busy;
            rx_valid_o <= 1'b0;
            if (load)
            begin
                sr    <= tx_data_i;
                sdo_q <= tx_data_i[SSP_BITS-1];
            end
            else if (trail)
            begin
                sr  <= {sr[SSP_BITS-2:0], link.peer_sdi};
                cnt <= cnt + 3'h1;
                if (cnt == 3'h7)
                begin
                    rx_data_o  <= {sr[SSP_BITS-2:0], link.peer_sdi};
                    rx_valid_o <= 1'b1;
                end
            end
            else if (lead)
                sdo_q <= sr[SSP_BITS-1];
        end
    end
endmodule : ssp_peer

// [bench/ssp_assertions.sv]
`timescale 1ns/100ps
module ssp_assertions (
    // System
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Link
    input  wire logic dev_sck_o,
    input  wire logic dev_sck_oe,
    input  wire logic dev_sdo_oe,
    input  wire logic peer_sck_oe,
    input  wire logic sck,
    input  wire logic ss_n
);
    logic [4:0] tog_cnt;
    logic       sck_q;
    logic       lead_lvl;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    always_ff @(posedge clk_i)
        sck_q <= sck;

    // Edges counted only inside a selected frame
    always_ff @(posedge clk_i)
        if (rst_i || ss_n)
            tog_cnt <= 5'h00;
        else if (sck != sck_q)
            tog_cnt <= tog_cnt + 5'h01;

    always_ff @(posedge clk_i)
        if ($fell(ss_n))
            lead_lvl <= sck;

    sck_contend_a: assert property (!(dev_sck_oe && peer_sck_oe))
        else $error("both ends drive the serial clock");
    sck_with_data_a: assert property (dev_sck_oe |-> dev_sdo_oe)
        else $error("clock driven without data out");
    sck_half_min_a: assert property ((dev_sck_oe && $changed(dev_sck_o))
        |=> $stable(dev_sck_o))
        else $error("clock half period under two cycles");
    frame_toggles_a: assert property ($rose(ss_n) |-> tog_cnt == 5'h10)
        else $error("frame did not carry sixteen clock edges");
    frame_length_a: assert property ($fell(ss_n) |-> ##[32:100] $rose(ss_n))
        else $error("frame length out of range");
    frame_lead_a: assert property ($fell(ss_n) |-> $stable(sck) [*2])
        else $error("clock moved at frame start");
    frame_end_a: assert property ($rose(ss_n) |-> $stable(sck) [*3])
        else $error("clock moved after frame end");
    frame_idle_a: assert property ($rose(ss_n) |-> sck == lead_lvl)
        else $error("clock not back at idle level");
endmodule : ssp_assertions

// [bench/tb.sv]
`timescale 1ns/100ps
module tb
    import ssp_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        timer_two_output_i = 1'b0;
    logic [1:0]  tcnt = 2'h0;
    logic        pm = 1'b0;
    logic        pckp = 1'b0;
    logic        pstart = 1'b0;
    logic [7:0]  ptx = 8'h00;
    logic        pbusy;
    logic [7:0]  prx;
    logic [2:0]  pins;
    logic [31:0] q;
    logic [7:0]  d;
    logic [7:0]  p;
    logic [7:0]  cfg;
    int          err_count = 0;
    int          compares = 0;

    always #20 clk_i = ~clk_i;

    // Timer pulse every fourth cycle keeps the half period legal
    always @(posedge clk_i)
    begin
        tcnt <= tcnt + 2'h1;
        timer_two_output_i <= (tcnt == 2'h3);
    end

    ssp_link_if ssp_link_if_inst ();
    assign pins = {ssp_link_if_inst.sck, ssp_link_if_inst.dev_sck_oe,
                   ssp_link_if_inst.dev_sdo_oe};

    ssp_port ssp_port_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .timer_two_output_i, .link(ssp_link_if_inst));
    ssp_peer #(.HALF_CYCLES(4)) ssp_peer_inst (.clk_i, .rst_i,
        .master_mode_i(pm), .ckp_i(pckp), .start_i(pstart), .tx_data_i(ptx),
        .busy_o(pbusy), .rx_data_o(prx), .rx_valid_o(),
        .link(ssp_link_if_inst));
    ssp_assertions ssp_assertions_inst (.clk_i, .rst_i,
        .dev_sck_o(ssp_link_if_inst.dev_sck_o),
        .dev_sck_oe(ssp_link_if_inst.dev_sck_oe),
        .dev_sdo_oe(ssp_link_if_inst.dev_sdo_oe),
        .peer_sck_oe(ssp_link_if_inst.peer_sck_oe),
        .sck(ssp_link_if_inst.sck), .ss_n(ssp_link_if_inst.ss_n));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] exp_ctrl(input logic [7:0] c,
                                            input logic       wc,
                                            input logic       ov);
        return {wc, ov, c[5:0]};
    endfunction : exp_ctrl

    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, v};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16)
            err_count++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wb(a, 1'b0, 8'h00);
        check(q, {24'h0, exp});
    endtask : rd

    // Poll until idle with a byte waiting
    task automatic wait_done();
        int n;
        n = 0;
        do
        begin
            wb(SSP_OFF_STAT, 1'b0, 8'h00);
            n++;
        end
        while ((q[STAT_BUSY_BIT] !== 1'b0 || q[STAT_BF_BIT] !== 1'b1)
               && n < 600);
        if (n >= 600)
            err_count++;
    endtask : wait_done

    task automatic peer_go(input logic [7:0] b, input logic wait_end);
        int n;
        n = 0;
        @(posedge clk_i);
        ptx    <= b;
        pstart <= 1'b1;
        @(posedge clk_i);
        pstart <= 1'b0;
        // Busy shows two edges after start, so skip the stale low
        while (wait_end && n < 400)
        begin
            @(posedge clk_i);
            n++;
            if (n > 2 && pbusy === 1'b0)
                break;
        end
    endtask : peer_go

    task automatic complete_run();
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        complete_run();
    end

    initial
    begin
        void'($urandom(94));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SSP_OFF_CTRL, CTRL_RESET);
        rd(8'h0c, 8'h00);
        check({29'h0, pins}, 32'h0);
        // Device master, peer slave, every rate code
        for (int i = 0; i < 4; i++)
        begin
            cfg = {6'b001000, i[1:0]};
            p = 8'($urandom);
            d = 8'($urandom);
            peer_go(p, 1'b0);
            wb(SSP_OFF_CTRL, 1'b1, cfg);
            repeat (2) @(posedge clk_i);
            check({29'h0, pins}, 32'h3);
            wb(SSP_OFF_BUF, 1'b1, d);
            wb(SSP_OFF_BUF, 1'b1, ~d);
            rd(SSP_OFF_CTRL, exp_ctrl(cfg, 1'b1, 1'b0));
            wb(SSP_OFF_CTRL, 1'b1, cfg);
            rd(SSP_OFF_CTRL, exp_ctrl(cfg, 1'b0, 1'b0));
            wait_done();
            check({24'h0, prx}, {24'h0, d});
            rd(SSP_OFF_STAT, 8'h03);
            peer_go(~p, 1'b0);
            wb(SSP_OFF_BUF, 1'b1, ~d);
            wait_done();
            rd(SSP_OFF_CTRL, exp_ctrl(cfg, 1'b0, 1'b0));
            rd(SSP_OFF_BUF, ~p);
            rd(SSP_OFF_STAT, 8'h02);
            wb(SSP_OFF_STAT, 1'b1, 8'h00);
            check({24'h0, prx}, {24'h0, ~d});
        end
        wb(SSP_OFF_CTRL, 1'b1, 8'h00);
        repeat (2) @(posedge clk_i);
        check({29'h0, pins}, 32'h0);
        // Peer master, device slave with and without select
        pm <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            cfg = {3'b001, i[0], 3'b010, i[1]};
            pckp <= i[0];
            p = 8'($urandom);
            d = 8'($urandom);
            wb(SSP_OFF_CTRL, 1'b1, cfg);
            wb(SSP_OFF_BUF, 1'b1, d);
            peer_go(p, 1'b1);
            wait_done();
            rd(SSP_OFF_BUF, p);
            check({24'h0, prx}, {24'h0, d});
            check({29'h0, pins}, {29'h0, i[0], 1'b0, i[1]});
            peer_go(~p, 1'b1);
            peer_go(p, 1'b1);
            rd(SSP_OFF_CTRL, exp_ctrl(cfg, 1'b0, 1'b1));
            rd(SSP_OFF_BUF, ~p);
            wb(SSP_OFF_CTRL, 1'b1, 8'h00);
            wb(SSP_OFF_STAT, 1'b1, 8'h00);
        end
        complete_run();
    end
endmodule : tb
